// ### hdl/eap_regs.svh
// Purpose: Register map, field positions, reset values and counts of the energy core.
// Assumes: Byte addresses on an 8-bit register port, one 32-bit word per register.
// Notes:   Included by the core; definitions only.
//
// Functional notes
// - Signed cycle energy splits into positive/negative accumulators.
// - One apparent energy accumulator per phase.
// - Accumulator overflow sets that accumulator's own status bit (three per phase).
// - No rising crossing within timeout sets flag.
// - Masked missing-crossing flag sets global missing bit.
// - Enabled global missing bit drives interrupt low.
// - Order A,B,C clears phase bit; A,C,B sets.
// - Frame counter past cycle count snapshots, clears, triggers.
// - Raw accumulation continues during post-processing.
// - Phase A and C integrate own V times I.
// - Phase B product chosen by two-bit select.
// - Non-zero hold-off blocks accumulation, decrements per cycle.
// - Pulses disabled during hold-off; hold-off resets to five.
// - Current below non-zero creep threshold blocks accumulation.
// - Results are 64-bit words, 48 bits significant.
// - Displayed RMS equals raw RMS times scale.
// - Displayed power equals energy times scale over count.
// - Scale coefficients only affect display conversion.
// - Any overflow sets global overflow bit.
// - Finished post-processing sets global cycle-ready bit.
`ifndef EAP_REGS_SVH
`define EAP_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define EAP_OFS_CTRL     8'h00
`define EAP_OFS_NS       8'h04
`define EAP_OFS_ZXTO     8'h08
`define EAP_OFS_HOLD     8'h0c
`define EAP_OFS_CREEP    8'h10
`define EAP_OFS_VCC      8'h14
`define EAP_OFS_ICC      8'h18
`define EAP_OFS_PCC      8'h1c
`define EAP_OFS_GFLAG    8'h20
`define EAP_OFS_MISS     8'h24
`define EAP_OFS_OVF      8'h28
`define EAP_OFS_STAT     8'h2c
`define EAP_OFS_RSEL     8'h30
`define EAP_OFS_RLO      8'h34
`define EAP_OFS_RHI      8'h38

// ****************************************************************
// Fields
// ****************************************************************
`define EAP_CTRL_BSEL    1:0
`define EAP_CTRL_MASK    2
`define EAP_CTRL_IEN     3
`define EAP_G_OVF        0
`define EAP_G_RDY        1
`define EAP_G_MISS       2
`define EAP_ST_ORDER     0
`define EAP_ST_BUSY      1
`define EAP_ST_PEN       2

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define EAP_HOLD_RST     8'h05
`define EAP_NS_RST       16'h0100
`define EAP_ZXTO_RST     16'h0200
`define EAP_CREEP_SHIFT  16
`define EAP_DIV_STEPS    7'h40
`define EAP_SIG_BITS     48

`endif

// ### hdl/eap_pkg.sv
// Purpose: Shared types of the energy core.
// Assumes: Nothing beyond the register header.
// Notes:   Result groups select what the on-demand calculator produces.
package eap_pkg;

	typedef enum logic [1:0] {
		EAP_IDLE = 2'b00,
		EAP_MUL  = 2'b01,
		EAP_DIV  = 2'b10,
		EAP_DONE = 2'b11
	} eap_calc_t;

	typedef enum logic [2:0] {
		EAP_G_POS  = 3'b000,
		EAP_G_NEG  = 3'b001,
		EAP_G_APP  = 3'b010,
		EAP_G_VRMS = 3'b011,
		EAP_G_IRMS = 3'b100,
		EAP_G_PACT = 3'b101,
		EAP_G_PAPP = 3'b110
	} eap_grp_t;

endpackage : eap_pkg

// ### hdl/eap_top.sv
// Purpose: Energy accumulation, cycle post-processing and display scaling core.
// Assumes: Samples, crossings and RMS values arrive synchronous to ref_clk,
//          qualified by frame_tick; register port per house bus.
// Notes:   Post-processing of a snapshot takes one cycle, so it never overlaps the next one.
//
// Chosen here: the register offsets and the strobed register port.
`include "eap_regs.svh"

module eap_top #(
	parameter int DW = 16,
	parameter int AW = 48,
	parameter int CW = 16
) (
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	input  wire logic [7:0]           addr,
	input  wire logic [31:0]          wdata,
	input  wire logic                 wr_en,
	input  wire logic                 rd_en,
	output logic      [31:0]          rdata,
	input  wire logic                 frame_tick,
	input  wire logic signed [DW-1:0] volt_a,
	input  wire logic signed [DW-1:0] volt_b,
	input  wire logic signed [DW-1:0] volt_c,
	input  wire logic signed [DW-1:0] curr_a,
	input  wire logic signed [DW-1:0] curr_b,
	input  wire logic signed [DW-1:0] curr_c,
	input  wire logic [2:0]           zc_rise,
	input  wire logic [31:0]          vrms_a,
	input  wire logic [31:0]          vrms_b,
	input  wire logic [31:0]          vrms_c,
	input  wire logic [31:0]          irms_a,
	input  wire logic [31:0]          irms_b,
	input  wire logic [31:0]          irms_c,
	output logic                      irq_n,
	output logic                      pulse_enable
);

	// ****************************************************************
	// Register decode
	// ****************************************************************
	logic [3:0]    ctrl_q;
	logic [CW-1:0] cycle_frame_count_q;
	logic [15:0]   zero_cross_timeout_q;
	logic [7:0]    accumulation_holdoff_q;
	logic [16:0]   creep_threshold_q;
	logic [15:0]   voltage_scale_coeff_q;
	logic [15:0]   current_scale_coeff_q;
	logic [15:0]   power_scale_coeff_q;
	logic [2:0]    gflag_q;
	logic [2:0]    missing_crossing_flag_q;
	logic [8:0]    energy_overflow_status_q;
	logic          phase_order_bit_q;
	logic [4:0]    rsel_q;
	logic [63:0]   res_q;
	eap_pkg::eap_calc_t calc_q;

	wire w_ctrl  = wr_en && addr == `EAP_OFS_CTRL;
	wire w_ns    = wr_en && addr == `EAP_OFS_NS;
	wire w_zxto  = wr_en && addr == `EAP_OFS_ZXTO;
	wire w_hold  = wr_en && addr == `EAP_OFS_HOLD;
	wire w_creep = wr_en && addr == `EAP_OFS_CREEP;
	wire w_vcc   = wr_en && addr == `EAP_OFS_VCC;
	wire w_icc   = wr_en && addr == `EAP_OFS_ICC;
	wire w_pcc   = wr_en && addr == `EAP_OFS_PCC;
	wire w_gflag = wr_en && addr == `EAP_OFS_GFLAG;
	wire w_miss  = wr_en && addr == `EAP_OFS_MISS;
	wire w_ovf   = wr_en && addr == `EAP_OFS_OVF;
	wire w_rsel  = wr_en && addr == `EAP_OFS_RSEL;

	wire calc_busy = calc_q != eap_pkg::EAP_IDLE;
	wire hold_zero = accumulation_holdoff_q == 8'h00;

	logic [31:0] rdata_d;
	always_comb begin
		case (addr)
			`EAP_OFS_CTRL:  rdata_d = {28'h0, ctrl_q};
			`EAP_OFS_NS:    rdata_d = 32'(cycle_frame_count_q);
			`EAP_OFS_ZXTO:  rdata_d = {16'h0, zero_cross_timeout_q};
			`EAP_OFS_HOLD:  rdata_d = {24'h0, accumulation_holdoff_q};
			`EAP_OFS_CREEP: rdata_d = {15'h0, creep_threshold_q};
			`EAP_OFS_VCC:   rdata_d = {16'h0, voltage_scale_coeff_q};
			`EAP_OFS_ICC:   rdata_d = {16'h0, current_scale_coeff_q};
			`EAP_OFS_PCC:   rdata_d = {16'h0, power_scale_coeff_q};
			`EAP_OFS_GFLAG: rdata_d = {29'h0, gflag_q};
			`EAP_OFS_MISS:  rdata_d = {29'h0, missing_crossing_flag_q};
			`EAP_OFS_OVF:   rdata_d = {23'h0, energy_overflow_status_q};
			`EAP_OFS_STAT:  rdata_d = {29'h0, hold_zero, calc_busy, phase_order_bit_q};
			`EAP_OFS_RSEL:  rdata_d = {27'h0, rsel_q};
			`EAP_OFS_RLO:   rdata_d = res_q[31:0];
			`EAP_OFS_RHI:   rdata_d = res_q[63:32];
			default:        rdata_d = 32'h0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 32'h0;
		end else begin
			rdata <= rd_en ? rdata_d : 32'h0;
		end
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q                <= 4'h0;
			cycle_frame_count_q   <= `EAP_NS_RST;
			zero_cross_timeout_q  <= `EAP_ZXTO_RST;
			creep_threshold_q     <= 17'h0;
			voltage_scale_coeff_q <= 16'h0;
			current_scale_coeff_q <= 16'h0;
			power_scale_coeff_q   <= 16'h0;
		end else begin
			if (w_ctrl)  ctrl_q                <= wdata[3:0];
			if (w_ns)    cycle_frame_count_q   <= wdata[CW-1:0];
			if (w_zxto)  zero_cross_timeout_q  <= wdata[15:0];
			if (w_creep) creep_threshold_q     <= wdata[16:0];
			// Coefficients feed the result calculator only, never the accumulators.
			if (w_vcc)   voltage_scale_coeff_q <= wdata[15:0];
			if (w_icc)   current_scale_coeff_q <= wdata[15:0];
			if (w_pcc)   power_scale_coeff_q   <= wdata[15:0];
		end
	end

	// ****************************************************************
	// Per-frame products and cycle framing
	// ****************************************************************
	wire signed [DW:0]     vac_sum = (DW+1)'(volt_a) + (DW+1)'(volt_c);
	logic signed [2*DW:0]  prod_b;
	always_comb begin
		case (ctrl_q[`EAP_CTRL_BSEL])
			2'b00:   prod_b = (2*DW+1)'(volt_b * curr_b);
			2'b01:   prod_b = (2*DW+1)'(-(curr_b * volt_c));
			default: prod_b = (2*DW+1)'(-(curr_b * vac_sum));
		endcase
	end

	logic signed [2:0][AW-1:0] fr_p;
	logic [2:0][AW-1:0]        fr_a;
	logic [2:0][31:0]          vrms;
	logic [2:0][31:0]          irms;
	assign fr_p[0] = AW'(volt_a * curr_a);
	assign fr_p[1] = AW'(prod_b);
	assign fr_p[2] = AW'(volt_c * curr_c);
	assign vrms    = {vrms_c, vrms_b, vrms_a};
	assign irms    = {irms_c, irms_b, irms_a};

	logic [CW-1:0] fcnt_q;
	logic          post_go_q;
	wire           cycle_end = frame_tick && fcnt_q >= cycle_frame_count_q;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			fcnt_q    <= '0;
			post_go_q <= 1'b0;
		end else begin
			if (frame_tick) fcnt_q <= cycle_end ? CW'(1) : fcnt_q + CW'(1);
			post_go_q <= cycle_end;
		end
	end

	// ****************************************************************
	// Raw integrals, snapshot and energy accumulators per phase
	// ****************************************************************
	logic [AW-1:0]      raw_p_q [3], raw_a_q [3], snap_p_q [3], snap_a_q [3];
	logic [AW-1:0]      pos_q [3], neg_q [3], app_q [3];
	logic [8:0]         ovf_set;

	for (genvar p = 0; p < 3; p++) begin : g_ph
		wire [AW-1:0] fa      = AW'(vrms[p][31:16] * irms[p][31:16]);
		wire [16:0]   irms_fs = 17'(irms[p] >> `EAP_CREEP_SHIFT);
		wire          creep   = creep_threshold_q != 17'h0 && irms_fs < creep_threshold_q;
		wire          acc_en  = post_go_q && hold_zero && !creep;
		wire          e_neg   = snap_p_q[p][AW-1];
		wire [AW-1:0] e_mag   = e_neg ? AW'(-snap_p_q[p]) : snap_p_q[p];
		wire [AW:0]   pos_sum = {1'b0, pos_q[p]} + {1'b0, e_mag};
		wire [AW:0]   neg_sum = {1'b0, neg_q[p]} + {1'b0, e_mag};
		wire [AW:0]   app_sum = {1'b0, app_q[p]} + {1'b0, snap_a_q[p]};
		wire          do_pos  = acc_en && !e_neg;
		wire          do_neg  = acc_en && e_neg;

		assign ovf_set[3*p]   = do_pos && pos_sum[AW];
		assign ovf_set[3*p+1] = do_neg && neg_sum[AW];
		assign ovf_set[3*p+2] = acc_en && app_sum[AW];

		always_ff @(posedge ref_clk or negedge arst_n) begin
			if (!arst_n) begin
				raw_p_q[p]  <= '0;
				raw_a_q[p]  <= '0;
				snap_p_q[p] <= '0;
				snap_a_q[p] <= '0;
				pos_q[p]    <= '0;
				neg_q[p]    <= '0;
				app_q[p]    <= '0;
			end else begin
				// The cycle-end frame opens the new integral, so no sample is lost.
				if (cycle_end) begin
					snap_p_q[p] <= raw_p_q[p];
					snap_a_q[p] <= raw_a_q[p];
					raw_p_q[p]  <= fr_p[p];
					raw_a_q[p]  <= fa;
				end else if (frame_tick) begin
					raw_p_q[p]  <= raw_p_q[p] + fr_p[p];
					raw_a_q[p]  <= raw_a_q[p] + fa;
				end
				// Sums drop their carry and keep going.
				if (do_pos) pos_q[p] <= pos_sum[AW-1:0];
				if (do_neg) neg_q[p] <= neg_sum[AW-1:0];
				if (acc_en) app_q[p] <= app_sum[AW-1:0];
			end
		end
	end

	// ****************************************************************
	// Hold-off, flags and interrupt
	// ****************************************************************
	logic [15:0]      zcnt_q [3];
	logic [2:0]       miss_set;
	for (genvar p = 0; p < 3; p++) begin : g_zx
		wire to_on = zero_cross_timeout_q != 16'h0;
		assign miss_set[p] = frame_tick && !zc_rise[p] && to_on
			&& zcnt_q[p] == zero_cross_timeout_q - 16'h1;
		always_ff @(posedge ref_clk or negedge arst_n) begin
			if (!arst_n) begin
				zcnt_q[p] <= 16'h0;
			end else if (frame_tick) begin
				if (zc_rise[p])
					zcnt_q[p] <= 16'h0;
				else if (zcnt_q[p] < zero_cross_timeout_q)
					zcnt_q[p] <= zcnt_q[p] + 16'h1;
			end
		end
	end

	logic a_last_q;
	logic [2:0] gflag_set;
	assign gflag_set[`EAP_G_OVF]  = |ovf_set;
	assign gflag_set[`EAP_G_RDY]  = post_go_q;
	assign gflag_set[`EAP_G_MISS] = ctrl_q[`EAP_CTRL_MASK] && |missing_crossing_flag_q;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			accumulation_holdoff_q   <= `EAP_HOLD_RST;
			gflag_q                  <= 3'h0;
			missing_crossing_flag_q  <= 3'h0;
			energy_overflow_status_q <= 9'h0;
			phase_order_bit_q        <= 1'b0;
			a_last_q                 <= 1'b0;
			irq_n                    <= 1'b1;
			pulse_enable             <= 1'b0;
		end else begin
			if (w_hold)
				accumulation_holdoff_q <= wdata[7:0];
			else if (post_go_q && !hold_zero)
				accumulation_holdoff_q <= accumulation_holdoff_q - 8'h1;
			// Host clears by writing zeros; a same-cycle set still wins.
			gflag_q <= (w_gflag ? gflag_q & wdata[2:0] : gflag_q) | gflag_set;
			missing_crossing_flag_q <= (w_miss ? missing_crossing_flag_q & wdata[2:0]
				: missing_crossing_flag_q) | miss_set;
			energy_overflow_status_q <= (w_ovf ? energy_overflow_status_q & wdata[8:0]
				: energy_overflow_status_q) | ovf_set;
			if (frame_tick && zc_rise[0])
				a_last_q <= 1'b1;
			else if (frame_tick && |zc_rise[2:1])
				a_last_q <= 1'b0;
			if (frame_tick && a_last_q && zc_rise[1])
				phase_order_bit_q <= 1'b0;
			else if (frame_tick && a_last_q && zc_rise[2])
				phase_order_bit_q <= 1'b1;
			irq_n <= !(ctrl_q[`EAP_CTRL_IEN] && gflag_q[`EAP_G_MISS]);
			pulse_enable <= hold_zero;
		end
	end

	// ****************************************************************
	// On-demand result calculator
	// ****************************************************************
	// Only the latched results are shown; a shared multiplier and a serial divider
	// trade latency for area.
	wire [1:0]  rph = rsel_q[1:0];
	wire [2:0]  grp = rsel_q[4:2];
	// Negate at the accumulator width, or a narrow build would see a wrong magnitude.
	wire [AW-1:0] pact_mag = snap_p_q[rph][AW-1] ? AW'(-snap_p_q[rph]) : snap_p_q[rph];
	logic [47:0] opnd;
	logic [15:0] coef;
	always_comb begin
		case (eap_pkg::eap_grp_t'(grp))
			eap_pkg::EAP_G_POS:  begin opnd = 48'(pos_q[rph]); coef = 16'h1; end
			eap_pkg::EAP_G_NEG:  begin opnd = 48'(neg_q[rph]); coef = 16'h1; end
			eap_pkg::EAP_G_APP:  begin opnd = 48'(app_q[rph]); coef = 16'h1; end
			eap_pkg::EAP_G_VRMS: begin opnd = 48'(vrms[rph]); coef = voltage_scale_coeff_q; end
			eap_pkg::EAP_G_IRMS: begin opnd = 48'(irms[rph]); coef = current_scale_coeff_q; end
			eap_pkg::EAP_G_PACT: begin
				opnd = 48'(pact_mag);
				coef = power_scale_coeff_q;
			end
			eap_pkg::EAP_G_PAPP: begin opnd = 48'(snap_a_q[rph]); coef = power_scale_coeff_q; end
			default:             begin opnd = 48'h0; coef = 16'h0; end
		endcase
	end

	wire         is_pwr = grp == eap_pkg::EAP_G_PACT || grp == eap_pkg::EAP_G_PAPP;
	wire [63:0]  prod   = 64'(opnd * coef);
	logic [CW:0] rem_q;
	logic [6:0]  step_q;
	wire  [CW:0] rem_sh = {rem_q[CW-1:0], res_q[63]};
	wire         rem_ge = rem_sh >= {1'b0, cycle_frame_count_q};

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			calc_q <= eap_pkg::EAP_IDLE;
			rsel_q <= 5'h0;
			res_q  <= 64'h0;
			rem_q  <= '0;
			step_q <= 7'h0;
		end else begin
			case (calc_q)
				eap_pkg::EAP_MUL: begin
					res_q  <= prod;
					rem_q  <= '0;
					step_q <= 7'h0;
					calc_q <= (is_pwr && cycle_frame_count_q != '0) ? eap_pkg::EAP_DIV
						: eap_pkg::EAP_DONE;
				end
				eap_pkg::EAP_DIV: begin
					rem_q  <= rem_ge ? rem_sh - {1'b0, cycle_frame_count_q} : rem_sh;
					res_q  <= {res_q[62:0], rem_ge};
					step_q <= step_q + 7'h1;
					if (step_q == `EAP_DIV_STEPS - 7'h1) calc_q <= eap_pkg::EAP_DONE;
				end
				eap_pkg::EAP_DONE: begin
					res_q  <= {16'h0, res_q[`EAP_SIG_BITS-1:0]};
					calc_q <= eap_pkg::EAP_IDLE;
				end
				default: calc_q <= eap_pkg::EAP_IDLE;
			endcase
			if (w_rsel) begin
				rsel_q <= wdata[4:0];
				calc_q <= eap_pkg::EAP_MUL;
			end
		end
	end

endmodule : eap_top

// ### sim/eap_props.sv
// Purpose: Port-level checks of the energy core.
// Assumes: Register port and flag timing as in the core's header.
// Notes:   Bound into eap_top at the foot of this file.
`include "eap_regs.svh"

module eap_props #(
	parameter int DW = 16,
	parameter int AW = 48,
	parameter int CW = 16
) (
	input wire logic        ref_clk,
	input wire logic        arst_n,
	input wire logic [7:0]  addr,
	input wire logic        wr_en,
	input wire logic        rd_en,
	input wire logic [31:0] rdata,
	input wire logic        frame_tick,
	input wire logic        irq_n,
	input wire logic        pulse_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// History of frames and writes
	// ****************************************************************
	// Flags only move some edges after a frame or a host write.
	logic [4:0] ft_q;
	logic [4:0] wr_q;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ft_q <= 5'h00;
			wr_q <= 5'h00;
		end else begin
			ft_q <= {ft_q[3:0], frame_tick};
			wr_q <= {wr_q[3:0], wr_en};
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	chk_rdata_quiet: assert property (!$past(rd_en) |-> rdata == 32'h0)
		else $error("read data not zero outside a read");
	chk_result_top: assert property (rd_en && addr == `EAP_OFS_RHI |=> rdata[31:16] == 16'h0)
		else $error("result word has more than 48 bits");
	chk_unmapped_zero: assert property (rd_en && addr == 8'h3c |=> rdata == 32'h0)
		else $error("unmapped read not zero");
	chk_ovf_width: assert property (rd_en && addr == `EAP_OFS_OVF |=> rdata[31:9] == 23'h0)
		else $error("overflow status has stray bits");
	chk_pulse_rise: assert property ($rose(pulse_enable) |-> (|ft_q[3:1]) || (|wr_q[2:1]))
		else $error("pulse enable rose without a cycle end");
	chk_pulse_fall: assert property ($fell(pulse_enable) |-> |wr_q[2:0])
		else $error("pulse enable fell without a write");
	chk_irq_fall: assert property ($fell(irq_n) |-> (|ft_q[4:1]) || (|wr_q[2:0]))
		else $error("interrupt asserted without cause");
	chk_irq_rise: assert property ($rose(irq_n) |-> |wr_q[3:0])
		else $error("interrupt released without host clear");
endmodule : eap_props

bind eap_top eap_props #(.DW(DW), .AW(AW), .CW(CW)) chk_u (
	.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
	.rdata(rdata), .frame_tick(frame_tick), .irq_n(irq_n), .pulse_enable(pulse_enable)
);

// ### sim/eap_host.sv
// Purpose: Host processor model driving the register port.
// Assumes: Read data stand in the cycle after the read strobe.
// Notes:   Tasks are called from the bench, one at a time.
`include "eap_regs.svh"

module eap_host (
	input  wire logic        ref_clk,
	output logic      [7:0]  addr,
	output logic      [31:0] wdata,
	output logic             wr_en,
	output logic             rd_en,
	input  wire logic [31:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	int ovf_seen;
	initial begin
		addr = 8'h00;
		wdata = 32'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		ovf_seen = 0;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1;
		d = rdata;
	endtask : rd

	// Overflows are counted before the status is cleared, or they are lost.
	task automatic clear_ovf();
		logic [31:0] d;
		rd(`EAP_OFS_OVF, d);
		ovf_seen += $countones(d);
		wr(`EAP_OFS_OVF, 32'h0);
		wr(`EAP_OFS_GFLAG, ~32'h1);
	endtask : clear_ovf

	task automatic clear_miss(input logic both);
		wr(`EAP_OFS_MISS, 32'h0);
		if (both)
			wr(`EAP_OFS_GFLAG, ~32'h4);
	endtask : clear_miss
endmodule : eap_host

// ### sim/energy_accumulation_postproc_test.sv
// Purpose: Self-checking bench of the energy core.
// Assumes: Accumulator width reduced to 40 bits so a wrap is cheap.
// Notes:   Load bursts are fenced by idle frames so no cycle mixes signs.
`include "eap_regs.svh"

module energy_accumulation_postproc_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int AWT = 40;
	logic               ref_clk = 1'b0;
	logic               arst_n = 1'b0;
	logic               frame_tick = 1'b0;
	logic        [2:0]  zc = 3'b000;
	logic signed [15:0] va, vb, vc, ia, ib, ic;
	logic        [31:0] vr_a = 32'h0, vr_b = 32'h0, vr_c = 32'h0;
	logic        [31:0] ir [3];
	logic        [7:0]  addr;
	logic        [31:0] wdata, rdata;
	logic               wr_en, rd_en, irq_n, pulse_enable;
	logic        [63:0] ep [3], en [3];
	int                 creep = 0, bad_count = 0, compares = 0;

	always #10 ref_clk = ~ref_clk;
	initial begin
		{va, vb, vc, ia, ib, ic} = '0;
		ir = '{32'h0002_0000, 32'h0002_0000, 32'h0002_0000};
		ep = '{64'h0, 64'h0, 64'h0};
		en = '{64'h0, 64'h0, 64'h0};
	end

	eap_host host_u (.ref_clk(ref_clk), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata));
	eap_top #(.AW(AWT)) dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.frame_tick(frame_tick), .volt_a(va), .volt_b(vb), .volt_c(vc), .curr_a(ia),
		.curr_b(ib), .curr_c(ic), .zc_rise(zc), .vrms_a(vr_a), .vrms_b(vr_b),
		.vrms_c(vr_c), .irms_a(ir[0]), .irms_b(ir[1]), .irms_c(ir[2]), .irq_n(irq_n),
		.pulse_enable(pulse_enable));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("compares %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	task automatic fr(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			frame_tick <= 1'b1;
			@(posedge ref_clk);
			frame_tick <= 1'b0;
		end
	endtask : fr

	task automatic res(input logic [4:0] sel, output logic [63:0] r);
		logic [31:0] lo, hi;
		host_u.wr(`EAP_OFS_RSEL, {27'h0, sel});
		// A power result runs the 64-step divider before it stands.
		repeat (70) @(posedge ref_clk);
		host_u.rd(`EAP_OFS_RLO, lo);
		host_u.rd(`EAP_OFS_RHI, hi);
		r = {hi, lo};
	endtask : res

	task automatic load(input int a, b, c, x, y, z, input logic [1:0] sel, input int n);
		longint p [3];
		logic [63:0] r;
		p[0] = a * x;
		p[1] = (sel == 2'd0) ? b * y : (sel == 2'd1) ? -y * c : -y * (a + c);
		p[2] = c * z;
		host_u.wr(`EAP_OFS_CTRL, {30'h0, sel});
		{va, vb, vc, ia, ib, ic} <= {16'(a), 16'(b), 16'(c), 16'(x), 16'(y), 16'(z)};
		fr(n);
		{va, vb, vc, ia, ib, ic} <= '0;
		fr(12);
		for (int k = 0; k < 3; k++) begin
			if (creep == 0 || ir[k][31:16] >= creep) begin
				if (p[k] > 0)
					ep[k] += 64'(n * p[k]);
				else
					en[k] += 64'(-n * p[k]);
			end
			res({3'd0, 2'(k)}, r);
			check(r, ep[k]);
			res({3'd1, 2'(k)}, r);
			check(r, en[k]);
		end
	endtask : load

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_holdoff();
		logic [31:0] d;
		logic [63:0] r;
		host_u.rd(`EAP_OFS_HOLD, d);
		check(64'(d), 64'h5);
		host_u.wr(`EAP_OFS_NS, 32'h4);
		host_u.wr(`EAP_OFS_ZXTO, 32'h0);
		fr(12);
		check(64'(pulse_enable), 64'h0);
		fr(18);
		check(64'(pulse_enable), 64'h1);
		host_u.wr(`EAP_OFS_GFLAG, 32'h0);
		host_u.rd(`EAP_OFS_GFLAG, d);
		check(64'(d[1]), 64'h0);
		fr(6);
		host_u.rd(`EAP_OFS_GFLAG, d);
		check(64'(d[1]), 64'h1);
		host_u.wr(`EAP_OFS_HOLD, 32'hff);
		repeat (4) @(posedge ref_clk);
		check(64'(pulse_enable), 64'h0);
		{va, ia} <= {16'sd100, 16'sd200};
		fr(8);
		{va, ia} <= '0;
		fr(12);
		res(5'd0, r);
		check(r, 64'h0);
		host_u.wr(`EAP_OFS_HOLD, 32'h0);
		repeat (4) @(posedge ref_clk);
		check(64'(pulse_enable), 64'h1);
	endtask : t_holdoff

	task automatic t_order();
		logic [31:0] d;
		int seq [2][3] = '{'{1, 2, 4}, '{1, 4, 2}};
		for (int s = 0; s < 2; s++) begin
			for (int k = 0; k < 3; k++) begin
				zc <= 3'(seq[s][k]);
				fr(1);
			end
			zc <= 3'b000;
			host_u.rd(`EAP_OFS_STAT, d);
			check(64'(d[0]), 64'(s));
		end
	endtask : t_order

	task automatic t_miss();
		logic [31:0] d;
		zc <= 3'b011;
		host_u.wr(`EAP_OFS_CTRL, 32'h8);
		host_u.wr(`EAP_OFS_ZXTO, 32'h4);
		fr(8);
		host_u.rd(`EAP_OFS_MISS, d);
		check(64'(d[2:0]), 64'h4);
		host_u.rd(`EAP_OFS_GFLAG, d);
		check(64'({d[2], irq_n}), 64'h1);
		host_u.wr(`EAP_OFS_CTRL, 32'hc);
		fr(8);
		host_u.rd(`EAP_OFS_GFLAG, d);
		check(64'({d[2], irq_n}), 64'h2);
		zc <= 3'b111;
		host_u.clear_miss(1'b0);
		fr(8);
		check(64'(irq_n), 64'h0);
		host_u.clear_miss(1'b1);
		repeat (3) @(posedge ref_clk);
		check(64'(irq_n), 64'h1);
	endtask : t_miss

	task automatic t_ovf_scale();
		logic [31:0] d;
		logic [63:0] r;
		{vr_c, ir[2]} <= {32'hffff_0000, 32'hffff_0000};
		fr(300);
		vr_c <= 32'h0;
		fr(12);
		res({3'd2, 2'd2}, r);
		check(r, (64'd300 * 64'hfffe_0001) & ((64'h1 << AWT) - 64'h1));
		host_u.rd(`EAP_OFS_OVF, d);
		check(64'(d), 64'h100);
		host_u.rd(`EAP_OFS_GFLAG, d);
		check(64'(d[0]), 64'h1);
		host_u.clear_ovf();
		host_u.rd(`EAP_OFS_OVF, d);
		check(64'({d, 32'(host_u.ovf_seen)}), 64'h1);
		host_u.wr(`EAP_OFS_ICC, 32'h0123);
		res({3'd4, 2'd0}, r);
		check(r, 64'h0246_0000);
		{vr_a, vr_b, va, ia} <= {32'h8000_0001, 32'h0001_0000, 16'sd100, -16'sd30};
		host_u.wr(`EAP_OFS_VCC, 32'hfffe);
		host_u.wr(`EAP_OFS_PCC, 32'h3);
		fr(12);
		res({3'd3, 2'd0}, r);
		check(r, 64'h7fff_0000_fffe);
		res({3'd3, 2'd1}, r);
		check(r, 64'hfffe_0000);
		res({3'd5, 2'd0}, r);
		check(r, 64'(4 * 3000 * 3 / 4));
		res({3'd6, 2'd0}, r);
		check(r, 64'(4 * 32'h8000 * 2 * 3 / 4));
		host_u.rd(8'h3c, d);
		check(64'(d), 64'h0);
	endtask : t_ovf_scale

	initial begin
		repeat (100000) @(posedge ref_clk);
		bad_count++;
		summarize();
	end

	initial begin
		repeat (16) @(posedge ref_clk);
		arst_n <= 1'b1;
		check(64'({pulse_enable, irq_n}), 64'h1);
		t_holdoff();
		load(100, 9, -300, 200, 0, 100, 2'd0, 8);
		load(-50, 0, 0, 200, 0, 0, 2'd0, 8);
		for (int s = 0; s < 4; s++)
			load(2, 3, 5, 0, -7, 0, 2'(s), 8);
		host_u.wr(`EAP_OFS_CREEP, 32'h1);
		creep = 1;
		ir[1] <= 32'h0000_ffff;
		load(10, 10, 10, 10, 10, 10, 2'd0, 8);
		ir[1] <= 32'h0001_0000;
		load(10, 10, 10, 10, 10, 10, 2'd0, 8);
		t_order();
		t_miss();
		t_ovf_scale();
		summarize();
	end
endmodule : energy_accumulation_postproc_test
